// ---- logic/amd_pkg.sv ----
// address map decoder package: map bounds, types, states and lane helpers
package amd_pkg;
  // ==========================================================
  // map bounds
  localparam logic [31:0] FLASH_LO  = 32'h0000_0000;
  localparam logic [31:0] FLASH_HI  = 32'h0000_7FFF;
  localparam logic [31:0] ROM_LO    = 32'h0100_0000;
  localparam logic [31:0] ROM_HI    = 32'h1FFF_FFFF;
  localparam logic [31:0] SRAM_LO   = 32'h2000_0000;
  localparam logic [31:0] SRAM_HI   = 32'h2000_2FFF;
  localparam logic [31:0] SALIAS_LO = 32'h2200_0000;
  localparam logic [31:0] SALIAS_HI = 32'h2205_FFFF;
  localparam logic [31:0] PERI_LO   = 32'h4000_0000;
  localparam logic [31:0] PERI_HI   = 32'h400F_FFFF;
  localparam logic [31:0] GAHB_LO   = 32'h4005_8000;
  localparam logic [31:0] GAHB_HI   = 32'h4005_DFFF;
  localparam logic [31:0] PALIAS_LO = 32'h4200_0000;
  localparam logic [31:0] PALIAS_HI = 32'h43FF_FFFF;
  localparam logic [31:0] TRACE_LO  = 32'hE000_0000;
  localparam logic [31:0] TRACE_HI  = 32'hE000_2FFF;
  localparam logic [31:0] CORE_LO   = 32'hE000_E000;
  localparam logic [31:0] CORE_HI   = 32'hE000_EFFF;
  localparam logic [31:0] TPORT_LO  = 32'hE004_0000;
  localparam logic [31:0] TPORT_HI  = 32'hE004_1FFF;
  // one bit per populated 4 KB page of 4000_0000-400F_FFFF
  localparam logic [255:0] PERI_PAGE_MAP =
    256'hF2000000000000000000800000000000000000003F01F00113FF003F000FFFF3;
  localparam logic [31:0] BEAT_STEP = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0]  STRB_ALL  = 4'hF;

  // ==========================================================
  // types
  typedef enum logic [1:0] {MT_NORMAL, MT_DEVICE, MT_STRONG} amd_mtype_e;
  typedef enum logic [3:0] {
    TGT_NONE, TGT_FLASH, TGT_ROM, TGT_SRAM, TGT_PERIPH, TGT_GPIO_AHB,
    TGT_PRIV_TRACE, TGT_PRIV_CORE, TGT_PRIV_PORT
  } amd_tgt_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE} amd_size_e;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ACC   = 5'h02,
    ST_RMW   = 5'h04,
    ST_HIGH  = 5'h08,
    ST_DRAIN = 5'h10
  } amd_state_e;

  // ==========================================================
  // helpers
  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [3:0] laneStrb(input logic [1:0] off, input amd_size_e sz);
    case (sz)
      SZ_BYTE: return 4'h1 << off;
      SZ_HALF: return 4'h3 << off;
      default: return STRB_ALL;
    endcase
  endfunction

  function automatic logic [31:0] placeData(input logic [1:0] off, input logic [31:0] d);
    return d << {off, 3'b000};
  endfunction
endpackage

// ---- logic/amd_attr_if.sv ----
// address to attribute carrier between the decoder and its user
`timescale 1ns/10ps
interface amd_attr_if;
  import amd_pkg::*;
  logic [31:0] addr;
  logic        isFetch;
  logic        protHit;
  amd_mtype_e  protType;
  logic        protNever;
  amd_tgt_e    sel;
  amd_mtype_e  mtype;
  logic        execNeverAttr;
  logic        resv;
  logic        bbAlias;
  modport dec (input addr, isFetch, protHit, protType, protNever,
               output sel, mtype, execNeverAttr, resv, bbAlias);
  modport host (output addr, isFetch, protHit, protType, protNever,
               input sel, mtype, execNeverAttr, resv, bbAlias);
endinterface

// ---- logic/amd_region_decode.sv ----
// region decoder: target select and memory attributes from one address
`timescale 1ns/10ps
module amd_region_decode
  import amd_pkg::*;
(
  // address and attributes
  amd_attr_if.dec at
);
  // ==========================================================
  // fixed target map, no software relocation
  always_comb
  begin
    at.sel     = TGT_NONE;
    at.bbAlias = 1'b0;
    if (inRange(at.addr, FLASH_LO, FLASH_HI))
      at.sel = TGT_FLASH;
    else if (inRange(at.addr, ROM_LO, ROM_HI))
      at.sel = TGT_ROM;
    else if (inRange(at.addr, SRAM_LO, SRAM_HI))
      at.sel = TGT_SRAM;
    else if (inRange(at.addr, SALIAS_LO, SALIAS_HI))
    begin
      at.sel     = TGT_SRAM;
      at.bbAlias = 1'b1;
    end
    else if (inRange(at.addr, GAHB_LO, GAHB_HI))
      at.sel = TGT_GPIO_AHB;
    else if (inRange(at.addr, PERI_LO, PERI_HI) && PERI_PAGE_MAP[at.addr[19:12]])
      at.sel = TGT_PERIPH;
    else if (inRange(at.addr, PALIAS_LO, PALIAS_HI))
    begin
      at.sel     = TGT_PERIPH;
      at.bbAlias = 1'b1;
    end
    else if (inRange(at.addr, TRACE_LO, TRACE_HI))
      at.sel = TGT_PRIV_TRACE;
    else if (inRange(at.addr, CORE_LO, CORE_HI))
      at.sel = TGT_PRIV_CORE;
    else if (inRange(at.addr, TPORT_LO, TPORT_HI))
      at.sel = TGT_PRIV_PORT;
    // fetches are never remapped through an alias
    at.resv = (at.sel == TGT_NONE) || (at.isFetch && at.bbAlias);
  end

  // ==========================================================
  // default type per 512 MB region, then protection override
  always_comb
  begin
    case (at.addr[31:29])
      3'h0, 3'h1, 3'h3, 3'h4:
      begin
        at.mtype         = MT_NORMAL;
        at.execNeverAttr = 1'b0;
      end
      3'h2, 3'h5, 3'h6:
      begin
        at.mtype         = MT_DEVICE;
        at.execNeverAttr = 1'b1;
      end
      default:
      begin
        at.mtype         = MT_STRONG;
        at.execNeverAttr = 1'b1;
      end
    endcase
    if (at.protHit)
    begin
      at.mtype         = at.protType;
      at.execNeverAttr = at.protNever;
    end
  end
endmodule

// ---- logic/amd_bitband.sv ----
// bit-band alias to word address, bit extract and bit merge
`timescale 1ns/10ps
module amd_bitband
(
  // alias access
  input  wire logic [31:0] aliasAddr,
  input  wire logic        bitIn,
  // underlying word
  input  wire logic [31:0] wordIn,
  output logic      [31:0] wordAddr,
  output logic             bitOut,
  output logic      [31:0] wordMerged
);
  logic [4:0] bitIdx;

  // each alias word selects one bit of the 1 MB bit-band region
  assign wordAddr = {aliasAddr[31:28], 8'h00, aliasAddr[24:7], 2'b00};
  assign bitIdx   = {aliasAddr[6:5], aliasAddr[4:2]};
  assign bitOut   = wordIn[bitIdx];

  always_comb
  begin
    wordMerged         = wordIn;
    wordMerged[bitIdx] = bitIn;
  end
endmodule

// ---- logic/amd_map_decoder.sv ----
// system address map decoder: routing, attributes, ordering and faults
`timescale 1ns/10ps
module amd_map_decoder
  import amd_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // instruction fetch port
  input  wire logic        iReq,
  input  wire logic [31:0] iAddr,
  input  wire logic        iProtHit,
  input  wire logic        iProtNever,
  output logic             iDone,
  output logic             iErr,
  output logic             iExecBlock,
  output logic      [31:0] iRdata,
  // data port
  input  wire logic        dReq,
  input  wire logic [31:0] dAddr,
  input  wire logic        dWrite,
  input  amd_size_e        dSize,
  input  wire logic [63:0] dWdata,
  input  wire logic        dProtHit,
  input  amd_mtype_e       dProtType,
  input  wire logic        dProtNever,
  output logic             dDone,
  output logic             dErr,
  output logic      [63:0] dRdata,
  // data attributes, same cycle as dAddr
  output amd_tgt_e         dSel,
  output amd_mtype_e       dType,
  output logic             dExecNever,
  // execute stage
  input  wire logic        execValid,
  input  wire logic        execNever,
  output logic             execNeverFault,
  // target bus
  output logic             tgtReq,
  output amd_tgt_e         tgtSel,
  output logic      [31:0] tgtAddr,
  output logic             tgtWrite,
  output logic      [3:0]  tgtStrb,
  output logic      [31:0] tgtWdata,
  input  wire logic        tgtAck,
  input  wire logic        tgtErr,
  input  wire logic [31:0] tgtRdata
);
  // ==========================================================
  // declarations
  amd_state_e  st;
  logic        curIsData;
  logic [31:0] curAddr;
  logic        curWrite;
  amd_size_e   curSize;
  logic        curAlias;
  logic [63:0] curWdata;
  logic [31:0] lowWord;
  logic        wbValid;
  amd_tgt_e    wbSel;
  logic [31:0] wbAddr;
  logic [3:0]  wbStrb;
  logic [31:0] wbData;
  logic        dTake;
  logic        iTake;
  logic        dOrdered;
  logic        dBufOk;
  logic        ack;
  logic        rmwGo;
  logic        hiGo;
  logic        fin;
  logic        aDErr;
  logic        aDrain;
  logic        aBuf;
  logic        aDAcc;
  logic        aIErr;
  logic        aINever;
  logic        aIAcc;
  logic [31:0] bbAddrIn;
  logic [31:0] bbWordAddr;
  logic        bbBit;
  logic [31:0] bbMerged;

  // ==========================================================
  // decoders
  amd_attr_if ia ();
  amd_attr_if da ();

  assign ia.addr      = iAddr;
  assign ia.isFetch   = 1'b1;
  assign ia.protHit   = iProtHit;
  assign ia.protType  = MT_NORMAL;
  assign ia.protNever = iProtNever;
  assign da.addr      = dAddr;
  assign da.isFetch   = 1'b0;
  assign da.protHit   = dProtHit;
  assign da.protType  = dProtType;
  assign da.protNever = dProtNever;

  amd_region_decode uDecI (
    .at (ia)
  );

  amd_region_decode uDecD (
    .at (da)
  );

  assign dSel       = da.sel;
  assign dType      = da.mtype;
  assign dExecNever = da.execNeverAttr;

  // alias math follows the incoming address while idle
  assign bbAddrIn = (st == ST_IDLE) ? dAddr : curAddr;

  amd_bitband uBb (
    .aliasAddr  (bbAddrIn),
    .bitIn      (curWdata[0]),
    .wordIn     (tgtRdata),
    .wordAddr   (bbWordAddr),
    .bitOut     (bbBit),
    .wordMerged (bbMerged)
  );

  // ==========================================================
  // request selection while idle
  // the cycle of a done pulse is skipped so a held request is not taken twice
  assign dTake    = (st == ST_IDLE) && dReq && !dDone;
  assign iTake    = (st == ST_IDLE) && iReq && !iDone;
  assign dOrdered = (da.mtype != MT_NORMAL);
  assign dBufOk   = (da.mtype == MT_DEVICE) && dWrite && !da.bbAlias &&
                    (dSize != SZ_DOUBLE) && !wbValid;

  always_comb
  begin
    aDErr   = 1'b0;
    aDrain  = 1'b0;
    aBuf    = 1'b0;
    aDAcc   = 1'b0;
    aIErr   = 1'b0;
    aINever = 1'b0;
    aIAcc   = 1'b0;
    if (dTake)
    begin
      if (da.resv)
        aDErr = 1'b1;
      else if (dOrdered && wbValid)
        aDrain = 1'b1;
      else if (dBufOk)
        aBuf = 1'b1;
      else
        aDAcc = 1'b1;
    end
    else if ((st == ST_IDLE) && wbValid)
      aDrain = 1'b1;
    else if (iTake)
    begin
      if (ia.resv)
        aIErr = 1'b1;
      else if (ia.execNeverAttr)
        aINever = 1'b1;
      else
        aIAcc = 1'b1;
    end
  end

  // ==========================================================
  // completion decode on the target bus
  assign ack   = tgtReq && tgtAck;
  assign rmwGo = ack && (st == ST_ACC) && curAlias && curWrite && !tgtErr;
  assign hiGo  = ack && (st == ST_ACC) && (curSize == SZ_DOUBLE) && !curAlias && !tgtErr;
  assign fin   = ack && !rmwGo && !hiGo && (st != ST_DRAIN);

  // ==========================================================
  // state machine, one transfer on the target bus at a time
  always_ff @(posedge core_clk)
  begin
    if (rst)
      st <= ST_IDLE;
    else
    begin
      case (st)
        ST_IDLE:
        begin
          if (aDrain)
            st <= ST_DRAIN;
          else if (aDAcc || aIAcc)
            st <= ST_ACC;
        end
        ST_ACC:
        begin
          if (rmwGo)
            st <= ST_RMW;
          else if (hiGo)
            st <= ST_HIGH;
          else if (ack)
            st <= ST_IDLE;
        end
        ST_RMW, ST_HIGH, ST_DRAIN:
        begin
          if (ack)
            st <= ST_IDLE;
        end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // current transfer capture
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      curIsData <= 1'b0;
      curAddr   <= ZERO_WORD;
      curWrite  <= 1'b0;
      curSize   <= SZ_WORD;
      curAlias  <= 1'b0;
      curWdata  <= {ZERO_WORD, ZERO_WORD};
    end
    else if (aDAcc)
    begin
      curIsData <= 1'b1;
      curAddr   <= dAddr;
      curWrite  <= dWrite;
      curSize   <= dSize;
      curAlias  <= da.bbAlias;
      curWdata  <= dWdata;
    end
    else if (aIAcc)
    begin
      curIsData <= 1'b0;
      curAddr   <= iAddr;
      curWrite  <= 1'b0;
      curSize   <= SZ_WORD;
      curAlias  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      lowWord <= ZERO_WORD;
    else if (hiGo)
      lowWord <= tgtRdata;
  end

  // ==========================================================
  // device write buffer, one entry
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wbValid <= 1'b0;
      wbSel   <= TGT_NONE;
      wbAddr  <= ZERO_WORD;
      wbStrb  <= 4'h0;
      wbData  <= ZERO_WORD;
    end
    else if (aBuf)
    begin
      wbValid <= 1'b1;
      wbSel   <= da.sel;
      wbAddr  <= dAddr;
      wbStrb  <= laneStrb(dAddr[1:0], dSize);
      wbData  <= placeData(dAddr[1:0], dWdata[31:0]);
    end
    else if (ack && (st == ST_DRAIN))
      wbValid <= 1'b0;
  end

  // ==========================================================
  // target bus driver
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tgtReq   <= 1'b0;
      tgtSel   <= TGT_NONE;
      tgtAddr  <= ZERO_WORD;
      tgtWrite <= 1'b0;
      tgtStrb  <= 4'h0;
      tgtWdata <= ZERO_WORD;
    end
    else if (aDrain)
    begin
      tgtReq   <= 1'b1;
      tgtSel   <= wbSel;
      tgtAddr  <= wbAddr;
      tgtWrite <= 1'b1;
      tgtStrb  <= wbStrb;
      tgtWdata <= wbData;
    end
    else if (aDAcc)
    begin
      tgtReq   <= 1'b1;
      tgtSel   <= da.sel;
      tgtAddr  <= da.bbAlias ? bbWordAddr : dAddr;
      tgtWrite <= dWrite && !da.bbAlias;
      tgtStrb  <= da.bbAlias ? STRB_ALL : laneStrb(dAddr[1:0], dSize);
      tgtWdata <= placeData(dAddr[1:0], dWdata[31:0]);
    end
    else if (aIAcc)
    begin
      tgtReq   <= 1'b1;
      tgtSel   <= ia.sel;
      tgtAddr  <= {iAddr[31:2], 2'b00};
      tgtWrite <= 1'b0;
      tgtStrb  <= STRB_ALL;
    end
    else if (rmwGo)
    begin
      tgtWrite <= 1'b1;
      tgtWdata <= bbMerged;
    end
    else if (hiGo)
    begin
      tgtAddr  <= tgtAddr + BEAT_STEP;
      tgtWdata <= curWdata[63:32];
    end
    else if (ack)
      tgtReq <= 1'b0;
  end

  // ==========================================================
  // answers to the core
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dDone  <= 1'b0;
      dErr   <= 1'b0;
      dRdata <= {ZERO_WORD, ZERO_WORD};
    end
    else
    begin
      dDone <= aDErr || aBuf || (fin && curIsData);
      dErr  <= aDErr || (fin && curIsData && tgtErr);
      if (fin && curIsData)
      begin
        if (curAlias)
          dRdata <= {ZERO_WORD, 31'h0000_0000, bbBit};
        else if (st == ST_HIGH)
          dRdata <= {tgtRdata, lowWord};
        else
          dRdata <= {ZERO_WORD, tgtRdata >> {curAddr[1:0], 3'b000}};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      iDone      <= 1'b0;
      iErr       <= 1'b0;
      iExecBlock <= 1'b0;
      iRdata     <= ZERO_WORD;
    end
    else
    begin
      iDone      <= aIErr || aINever || (fin && !curIsData);
      iErr       <= aIErr || (fin && !curIsData && tgtErr);
      iExecBlock <= aINever;
      if (fin && !curIsData)
        iRdata <= tgtRdata;
      else if (aIErr || aINever)
        iRdata <= ZERO_WORD;
    end
  end

  // fault only once a blocked instruction reaches execute
  always_ff @(posedge core_clk)
  begin
    if (rst)
      execNeverFault <= 1'b0;
    else
      execNeverFault <= execValid && execNever;
  end

  // ==========================================================
  // checks
  AST_RESV_FAULT:
    assert property (@(posedge core_clk) disable iff (rst)
      aDErr |=> dDone && dErr && !tgtReq)
    else $error("reserved data access not faulted");

  AST_SRAM_ROUTE:
    assert property (@(posedge core_clk) disable iff (rst)
      dReq && (dAddr == SRAM_HI) |-> (dSel == TGT_SRAM) && !da.resv)
    else $error("sram top word not routed");

  AST_PALIAS:
    assert property (@(posedge core_clk) disable iff (rst)
      aDAcc && (dAddr == PALIAS_HI - 32'h0000_0003) |=> tgtAddr == PERI_HI - 32'h0000_0003)
    else $error("peripheral alias top word mis-mapped");

  AST_GPIO_AHB:
    assert property (@(posedge core_clk) disable iff (rst)
      dReq && inRange(dAddr, GAHB_LO, GAHB_HI) |-> dSel == TGT_GPIO_AHB)
    else $error("gpio aperture not selected");

  AST_CORE_PERIPH:
    assert property (@(posedge core_clk) disable iff (rst)
      dReq && !dProtHit && inRange(dAddr, CORE_LO, CORE_HI)
      |-> dSel == TGT_PRIV_CORE && dType == MT_STRONG)
    else $error("core peripheral window wrong");

  AST_DEV_NEVER:
    assert property (@(posedge core_clk) disable iff (rst)
      dReq && !dProtHit && (dAddr[31:29] == 3'h5) |-> dType == MT_DEVICE && dExecNever)
    else $error("device region attributes wrong");

  AST_SO_ORDER:
    assert property (@(posedge core_clk) disable iff (rst)
      aDAcc && dOrdered |-> !wbValid)
    else $error("ordered access overtook buffered write");

  AST_SO_NOBUF:
    assert property (@(posedge core_clk) disable iff (rst)
      aBuf |-> da.mtype == MT_DEVICE ##1 wbValid && dDone && !tgtReq)
    else $error("write buffer misuse");

  AST_NEVER_FETCH:
    assert property (@(posedge core_clk) disable iff (rst)
      aINever |=> iDone && iExecBlock && !iErr && !tgtReq &&
                  (!execNeverFault || $past(execValid && execNever)))
    else $error("execute-never fetch not blocked");

  AST_NEVER_FAULT:
    assert property (@(posedge core_clk) disable iff (rst)
      execNeverFault |-> $past(execValid) && $past(execNever))
    else $error("fault without execution");

  AST_LE_BYTE:
    assert property (@(posedge core_clk) disable iff (rst)
      aDAcc && dWrite && !da.bbAlias && dSize == SZ_BYTE && dAddr[1:0] == 2'h3
      |=> tgtStrb == 4'h8 && tgtWdata[31:24] == $past(dWdata[7:0]))
    else $error("byte lane not little endian");

  AST_DOUBLE:
    assert property (@(posedge core_clk) disable iff (rst)
      hiGo |=> st == ST_HIGH && tgtReq && tgtAddr == $past(tgtAddr) + BEAT_STEP)
    else $error("second beat not at next word");

  AST_RMW:
    assert property (@(posedge core_clk) disable iff (rst)
      rmwGo |=> tgtReq && tgtWrite && tgtAddr == $past(tgtAddr) && tgtStrb == STRB_ALL)
    else $error("alias write not read-modify-write");
endmodule

// ---- sim/amd_tgt_model.sv ----
// target side model: word memory behind the target bus, random ack latency
`timescale 1ns/10ps
module amd_tgt_model
  import amd_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // target bus
  input  wire logic        tgtReq,
  input  amd_tgt_e         tgtSel,
  input  wire logic [31:0] tgtAddr,
  input  wire logic        tgtWrite,
  input  wire logic [3:0]  tgtStrb,
  input  wire logic [31:0] tgtWdata,
  output logic             tgtAck,
  output logic             tgtErr,
  output logic      [31:0] tgtRdata
);
  logic [31:0] mem [logic [29:0]];
  logic [31:0] word;
  integer      seed = 32'h9047;
  int          waitCnt;

  initial
  begin
    tgtAck = 1'b0;
    tgtErr = 1'b0;
    tgtRdata = 32'h0;
    waitCnt = 0;
  end

  // idle data lines toggle so stale values never look valid
  always @(posedge core_clk)
  begin
    tgtAck <= 1'b0;
    tgtErr <= 1'b0;
    tgtRdata <= ~tgtRdata;
    if (rst)
      waitCnt = 0;
    else if (tgtReq && !tgtAck && waitCnt > 0)
      waitCnt--;
    else if (tgtReq && !tgtAck)
    begin
      word = mem.exists(tgtAddr[31:2]) ? mem[tgtAddr[31:2]] : 32'h0;
      for (int k = 0; k < 4; k++)
        if (tgtWrite && tgtStrb[k])
          word[8*k +: 8] = tgtWdata[8*k +: 8];
      mem[tgtAddr[31:2]] = word;
      tgtRdata <= word;
      tgtAck <= 1'b1;
      // rom target answers with an error to exercise the fault path
      tgtErr <= (tgtSel == TGT_ROM);
      waitCnt = {$random(seed)} % 3;
    end
  end
endmodule

// ---- sim/amd_map_decoder_test.sv ----
// bench for the map decoder against a reference word map
`timescale 1ns/10ps
module amd_map_decoder_test;
  import amd_pkg::*;
  logic core_clk, rst, iReq, iDone, iErr, iExecBlock, dReq, dWrite, dDone, dErr;
  logic dExecNever, execValid, execNever, execNeverFault, tgtReq, tgtWrite, tgtAck, tgtErr;
  logic [31:0] iAddr, iRdata, dAddr, tgtAddr, tgtWdata, tgtRdata, w;
  logic [63:0] dWdata, dRdata, rd, rv;
  logic [33:0] fr;
  logic [3:0]  tgtStrb;
  amd_size_e   dSize;
  amd_tgt_e    dSel, tgtSel;
  amd_mtype_e  dType, dProtType;
  logic        iProtHit, iProtNever, dProtHit, dProtNever;
  logic [31:0] refm [logic [29:0]];
  logic        er;
  int          errors, comparisons, k;
  integer      seed = 32'h9047;
  logic [38:0] tab [6] = '{{32'h0000_0100, 7'h08}, {32'h2000_2FFC, 7'h18},
    {32'h4000_4000, 7'h23}, {32'h4005_D000, 7'h2B}, {32'hE000_E010, 7'h3D},
    {32'hA000_0000, 7'h03}};
  logic [31:0] resv [6] = '{32'h0000_8000, 32'h2000_3000, 32'h4000_2000,
    32'h2206_0000, 32'hE010_0000, 32'hA000_0000};

  amd_map_decoder dut_u (.core_clk, .rst, .iReq, .iAddr, .iProtHit,
    .iProtNever, .iDone, .iErr, .iExecBlock, .iRdata, .dReq, .dAddr, .dWrite,
    .dSize, .dWdata, .dProtHit, .dProtType, .dProtNever,
    .dDone, .dErr, .dRdata, .dSel, .dType, .dExecNever, .execValid, .execNever,
    .execNeverFault, .tgtReq, .tgtSel, .tgtAddr, .tgtWrite, .tgtStrb, .tgtWdata,
    .tgtAck, .tgtErr, .tgtRdata);
  amd_tgt_model tgt_u (.core_clk, .rst, .tgtReq, .tgtSel, .tgtAddr, .tgtWrite,
    .tgtStrb, .tgtWdata, .tgtAck, .tgtErr, .tgtRdata);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task chk(input string n, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task wrap_up;
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function logic [31:0] rw(input logic [31:0] a);
    return refm.exists(a[31:2]) ? refm[a[31:2]] : 32'h0;
  endfunction

  // one data transfer, request held until done
  task acc(input logic [31:0] a, input logic wr, input amd_size_e s, input logic [63:0] wd);
    @(negedge core_clk);
    dReq = 1'b1;
    dAddr = a;
    dWrite = wr;
    dSize = s;
    dWdata = wd;
    for (k = 0; k < 40 && dDone !== 1'b1; k++)
      @(posedge core_clk) #1;
    if (k == 40)
    begin
      errors++;
      wrap_up;
    end
    rd = dRdata;
    er = dErr;
    @(negedge core_clk);
    dReq = 1'b0;
  endtask

  task fetch(input logic [31:0] a);
    @(negedge core_clk);
    iReq = 1'b1;
    iAddr = a;
    for (k = 0; k < 40 && iDone !== 1'b1; k++)
      @(posedge core_clk) #1;
    if (k == 40)
    begin
      errors++;
      wrap_up;
    end
    fr = {iErr, iExecBlock, iRdata};
    @(negedge core_clk);
    iReq = 1'b0;
  endtask

  // write through the design and into the reference map
  task wr(input logic [31:0] a, input amd_size_e s, input logic [63:0] wd);
    acc(a, 1'b1, s, wd);
    w = rw(a);
    for (int b = 0; b < (1 << s) && b < 4; b++)
      w[8*(a[1:0]+b) +: 8] = wd[8*b +: 8];
    refm[a[31:2]] = w;
    if (s == SZ_DOUBLE)
      refm[a[31:2]+30'h1] = wd[63:32];
  endtask

  task rdChk(input logic [31:0] a, input amd_size_e s);
    logic [63:0] m;
    acc(a, 1'b0, s, 64'h0);
    m = s == SZ_BYTE ? 64'hFF : s == SZ_HALF ? 64'hFFFF : s == SZ_WORD ? 64'hFFFF_FFFF : '1;
    chk("dRdata", {rw(a + 32'h4), rw(a) >> (8*a[1:0])} & m, rd & m);
  endtask

  initial
  begin
    {iReq, dReq, dWrite, execValid, execNever} = '0;
    {iProtHit, iProtNever, dProtHit, dProtNever} = '0;
    dProtType = MT_NORMAL;
    {iAddr, dAddr, dWdata, errors, comparisons} = '0;
    dSize = SZ_WORD;
    rst = 1'b1;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    foreach (tab[i])
    begin
      dAddr = tab[i][38:7];
      #1 chk("attr", tab[i][6:0], {dSel, dType, dExecNever});
      @(negedge core_clk);
    end
    dProtHit = 1'b1;
    dProtType = MT_DEVICE;
    dProtNever = 1'b1;
    dAddr = 32'h2000_0000;
    #1 chk("attr", 7'h1B, {dSel, dType, dExecNever});
    dProtHit = 1'b0;
    iProtHit = 1'b1;
    iProtNever = 1'b1;
    fetch(32'h0000_0100);
    chk("fetch", {2'b01, 32'h0}, fr);
    iProtHit = 1'b0;
    acc(32'h0100_0000, 1'b0, SZ_WORD, 64'h0);
    chk("dErr", 64'h1, er);
    foreach (resv[i])
    begin
      acc(resv[i], i[0], SZ_WORD, 64'h0);
      chk("dErr", 64'h1, er);
    end
    rv = {$random(seed), $random(seed)};
    wr(32'h2000_0010, SZ_DOUBLE, rv);
    rdChk(32'h2000_0010, SZ_DOUBLE);
    wr(32'h2000_0023, SZ_BYTE, rv);
    wr(32'h2000_0020, SZ_HALF, rv);
    rdChk(32'h2000_0020, SZ_WORD);
    rdChk(32'h2000_0013, SZ_BYTE);
    rdChk(32'h2000_0016, SZ_HALF);
    wr(32'h4000_4000, SZ_WORD, rv);
    wr(32'h4005_8004, SZ_WORD, ~rv);
    rdChk(32'h4000_4000, SZ_WORD);
    wr(32'hE000_E010, SZ_WORD, rv >> 8);
    rdChk(32'h4005_8004, SZ_WORD);
    rdChk(32'hE000_E010, SZ_WORD);
    w = rw(32'h2000_0020);
    acc(32'h2200_042C, 1'b1, SZ_WORD, {63'h7F, ~w[11]});
    w[11] = ~w[11];
    refm[30'h0800_0008] = w;
    rdChk(32'h2000_0020, SZ_WORD);
    acc(32'h2200_042C, 1'b0, SZ_WORD, 64'h0);
    chk("alias", {63'h0, w[11]}, rd);
    acc(32'h43FF_FFFC, 1'b1, SZ_WORD, 64'h1);
    refm[30'h1003_FFFF] = rw(32'h400F_FFFC) | 32'h8000_0000;
    rdChk(32'h400F_FFFC, SZ_WORD);
    wr(32'h0000_0100, SZ_WORD, rv);
    fetch(32'h0000_0100);
    chk("fetch", {2'b00, rw(32'h100)}, fr);
    fetch(32'h4000_4000);
    chk("fetch", {2'b01, 32'h0}, fr);
    fetch(32'h0000_8000);
    chk("fetchErr", 64'h1, fr[33]);
    chk("fault", 64'h0, execNeverFault);
    execValid = 1'b1;
    execNever = 1'b1;
    @(negedge core_clk);
    chk("fault", 64'h1, execNeverFault);
    execNever = 1'b0;
    @(negedge core_clk);
    chk("fault", 64'h0, execNeverFault);
    wrap_up;
  end
endmodule
